// ---- rtl/dscp_top.sv ----
// Summary of operation
// - Strap high selects two-wire mode, strap low selects four-wire mode.
// - Two-wire port runs at standard and fast bit rates.
// - Two-wire writes carry one data byte; reads may be single or multi-byte.
// - Bus address is five upper bits plus upper then lower select pin.
// - Unconnected select pins read upper low, lower high: default address.
// - Override bit set takes upper address bits from config bits 6 to 2.
// - Soft reset written one forces the default upper address bits.
// - Host writes zero to soft reset to leave it; default address returns.
// - Write: start, address+0, register byte, data byte, stop; each acknowledged.
// - Read: set pointer with write phase and stop, restart with direction one.
// - Each host acknowledge in a read increments the pointer, sends next byte.
// - Four-wire access accepted only while chip select is low.
// - Four-wire clock up to the stated maximum rate.
// - Four-wire frame: direction byte, address byte, data byte; 24 bits.
// - Transmitter changes data on falling edge; receiver samples on rising.
// - Four-wire write passes write flag, address and data to the map.
// - Read data starts on falling edge after 16th rise; seven more bits follow.
// - Serial output does not echo bits the host sends.
// - One register per four-wire frame; no burst, no auto-increment.
// - Direction byte: first seven bits ignored, eighth selects write or read.
// - Write commits on the falling edge after the 24th rising edge.
// - Page number written to page select before accessing that page.
module dscp_top (
    // System
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // Straps and select pins
    input  wire logic       port_mode_select_i,
    input  wire logic       addr_select_upper_i,
    input  wire logic       addr_select_lower_i,
    // Serial link
    input  wire logic       serial_clock_i,
    input  wire logic       chip_select_low_ni,
    input  wire logic       serial_data_bidir_i,
    output logic            serial_data_bidir_o,
    output logic            serial_data_bidir_oe_o,
    output logic            serial_data_return_o,
    output logic            serial_data_return_oe_o,
    // Register map, system clock
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_page_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i,
    // Register map read, link clock
    output logic [7:0]      spi_rd_addr_o,
    input  wire logic [7:0] spi_rd_data_i,
    // Chip soft reset
    output logic            chip_reset_o
);

    typedef struct packed {
        logic [1:0]           mode_s;
        logic [1:0]           up_s;
        logic [1:0]           lo_s;
        logic [2:0]           scl_s;
        logic [2:0]           sda_s;
        logic [2:0]           tog_s;
        dscp_pkg::dscp_tw_st_t st;
        logic [3:0]           bits;
        logic [7:0]           sh;
        logic [1:0]           phase;
        logic                 rnw;
        logic                 ackd;
        logic [7:0]           ptr;
        logic                 sda_oe;
        logic [7:0]           page;
        logic [7:0]           cfg;
        logic [7:0]           srst;
        logic                 reg_wr;
        logic                 reg_rd;
        logic [7:0]           reg_addr;
        logic [7:0]           reg_wdata;
        logic                 sdo_oe;
        logic                 sda_o;
    } dscp_sys_t;

    typedef struct packed {
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        wr;
        logic [7:0]  addr;
    } dscp_lp_t;

    typedef struct packed {
        logic [7:0] tx;
        logic       serial_data_return;
        logic       done;
        logic       tog;
        logic [7:0] waddr;
        logic [7:0] wdata;
    } dscp_ln_t;

    dscp_sys_t s_q;
    dscp_sys_t s_d;
    dscp_lp_t  p_q;
    dscp_lp_t  p_d;
    dscp_ln_t  n_q;
    dscp_ln_t  n_d;

    logic spi_rst_n;

    // Local registers override the map on readback
    function automatic logic [7:0] dscp_rdmux(input logic [7:0] a,
                                              input logic [7:0] pg,
                                              input logic [7:0] cf,
                                              input logic [7:0] sr,
                                              input logic [7:0] ext);
        logic [7:0] r;
        r = ext;
        if (a == dscp_pkg::PAGE_SEL_OFS) begin
            r = pg;
        end else if (a == dscp_pkg::SOFT_RST_OFS) begin
            r = sr;
        end else if (a == dscp_pkg::ADDR_CFG_OFS && pg == dscp_pkg::PAGE_GENERIC) begin
            r = cf;
        end
        return r;
    endfunction : dscp_rdmux

    // System clock domain
    always_comb begin
        logic       two_wire;
        logic       scl_r;
        logic       scl_f;
        logic       start;
        logic       stop;
        logic       sda;
        logic       wr_en;
        logic [7:0] wr_a;
        logic [7:0] wr_dat;
        logic [4:0] upper;
        logic [6:0] own_addr;
        s_d = s_q;
        // Pins and straps pass two flops
        s_d.mode_s = {s_q.mode_s[0], port_mode_select_i};
        s_d.up_s = {s_q.up_s[0], addr_select_upper_i};
        s_d.lo_s = {s_q.lo_s[0], addr_select_lower_i};
        s_d.scl_s = {s_q.scl_s[1:0], serial_clock_i};
        s_d.sda_s = {s_q.sda_s[1:0], serial_data_bidir_i};
        s_d.tog_s = {s_q.tog_s[1:0], n_q.tog};
        two_wire = (s_q.mode_s[1] == dscp_pkg::MODE_TWO_WIRE);
        sda = s_q.sda_s[1];
        // Edges and bus conditions from the synced lines
        scl_r = s_q.scl_s[1] & ~s_q.scl_s[2];
        scl_f = ~s_q.scl_s[1] & s_q.scl_s[2];
        start = s_q.scl_s[1] & s_q.scl_s[2] & ~s_q.sda_s[1] & s_q.sda_s[2];
        stop = s_q.scl_s[1] & s_q.scl_s[2] & s_q.sda_s[1] & ~s_q.sda_s[2];
        wr_en = 1'b0;
        wr_a = s_q.ptr;
        wr_dat = s_q.sh;
        s_d.reg_wr = 1'b0;
        s_d.reg_rd = 1'b0;
        s_d.sdo_oe = ~two_wire;
        s_d.sda_o = 1'b0;
        if (s_q.cfg[dscp_pkg::CFG_OVR_BIT] && !s_q.srst[dscp_pkg::SRST_BIT]) begin
            upper = s_q.cfg[dscp_pkg::CFG_HI_BIT:dscp_pkg::CFG_LO_BIT];
        end else begin
            upper = dscp_pkg::DEF_UPPER;
        end
        // Own bus address: upper bits, then the two select pins
        own_addr = {upper, s_q.up_s[1], s_q.lo_s[1]};
        // Read data from the map is valid while the read strobe is high
        if (s_q.reg_rd) begin
            s_d.sh = dscp_rdmux(s_q.reg_addr, s_q.page, s_q.cfg, s_q.srst, reg_rdata_i);
        end
        if (!two_wire) begin
            s_d.st = dscp_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (start) begin
            s_d.st = dscp_pkg::ST_RX;
            s_d.bits = '0;
            s_d.phase = dscp_pkg::PH_SLAVE;
            s_d.sda_oe = 1'b0;
        end else if (stop) begin
            s_d.st = dscp_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.st)
                dscp_pkg::ST_RX: begin
                    if (scl_r) begin
                        s_d.sh = {s_q.sh[6:0], sda};
                        s_d.bits = s_q.bits + 4'h1;
                    end else if (scl_f && s_q.bits == dscp_pkg::BYTE_BITS) begin
                        s_d.bits = '0;
                        s_d.st = dscp_pkg::ST_ACK;
                        s_d.sda_oe = 1'b1;
                        if (s_q.phase == dscp_pkg::PH_SLAVE) begin
                            if (s_q.sh[7:1] == own_addr) begin
                                s_d.rnw = s_q.sh[0];
                                s_d.reg_rd = s_q.sh[0];
                                s_d.reg_addr = s_q.ptr;
                            end else begin
                                s_d.st = dscp_pkg::ST_IDLE;
                                s_d.sda_oe = 1'b0;
                            end
                        end else if (s_q.phase == dscp_pkg::PH_REG) begin
                            s_d.ptr = s_q.sh;
                        end else if (s_q.phase == dscp_pkg::PH_DATA) begin
                            wr_en = 1'b1;
                        end else begin
                            s_d.st = dscp_pkg::ST_IDLE;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end
                dscp_pkg::ST_ACK: begin
                    if (scl_f) begin
                        if (s_q.rnw) begin
                            s_d.st = dscp_pkg::ST_TX;
                            s_d.sda_oe = ~s_q.sh[7];
                            s_d.bits = dscp_pkg::FIRST_BIT;
                        end else begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = dscp_pkg::ST_RX;
                            s_d.phase = s_q.phase + 2'h1;
                        end
                    end
                end
                dscp_pkg::ST_TX: begin
                    if (scl_f) begin
                        if (s_q.bits == dscp_pkg::BYTE_BITS) begin
                            s_d.sda_oe = 1'b0;
                            s_d.st = dscp_pkg::ST_RACK;
                            s_d.ackd = 1'b0;
                        end else begin
                            s_d.sda_oe = ~s_q.sh[6];
                            s_d.sh = {s_q.sh[6:0], 1'b0};
                            s_d.bits = s_q.bits + 4'h1;
                        end
                    end
                end
                dscp_pkg::ST_RACK: begin
                    if (scl_r) begin
                        if (!sda) begin
                            s_d.ackd = 1'b1;
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.reg_rd = 1'b1;
                            s_d.reg_addr = s_q.ptr + 8'h01;
                        end else begin
                            s_d.st = dscp_pkg::ST_IDLE;
                        end
                    end else if (scl_f && s_q.ackd) begin
                        s_d.st = dscp_pkg::ST_TX;
                        s_d.sda_oe = ~s_q.sh[7];
                        s_d.bits = dscp_pkg::FIRST_BIT;
                    end
                end
                default: begin
                    s_d.st = dscp_pkg::ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
        // Four-wire write arrives as a toggle from the link domain
        if (!two_wire && (s_q.tog_s[1] ^ s_q.tog_s[2])) begin
            wr_en = 1'b1;
            wr_a = n_q.waddr;
            wr_dat = n_q.wdata;
        end
        if (wr_en) begin
            s_d.reg_wr = 1'b1;
            s_d.reg_addr = wr_a;
            s_d.reg_wdata = wr_dat;
            if (wr_a == dscp_pkg::PAGE_SEL_OFS) begin
                s_d.page = wr_dat;
            end else if (wr_a == dscp_pkg::SOFT_RST_OFS) begin
                s_d.srst = wr_dat;
                // Reset state returns the address configuration to default
                if (wr_dat[dscp_pkg::SRST_BIT]) begin
                    s_d.cfg = dscp_pkg::ADDR_CFG_RST;
                end
            end else if (wr_a == dscp_pkg::ADDR_CFG_OFS
                         && s_q.page == dscp_pkg::PAGE_GENERIC) begin
                s_d.cfg = wr_dat;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '{mode_s: 2'h3, up_s: 2'h0, lo_s: 2'h0, scl_s: 3'h7, sda_s: 3'h7,
                     tog_s: 3'h0, st: dscp_pkg::ST_IDLE, bits: 4'h0, sh: 8'h00,
                     phase: 2'h0, rnw: 1'b0, ackd: 1'b0, ptr: 8'h00, sda_oe: 1'b0,
                     page: dscp_pkg::PAGE_SEL_RST, cfg: dscp_pkg::ADDR_CFG_RST,
                     srst: dscp_pkg::SOFT_RST_RST, reg_wr: 1'b0, reg_rd: 1'b0,
                     reg_addr: 8'h00, reg_wdata: 8'h00, sdo_oe: 1'b0,
                     sda_o: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Link domain, rising edge: frame is cleared while chip select is high
    assign spi_rst_n = resetn_i & ~chip_select_low_ni;

    always_comb begin
        p_d = p_q;
        if (p_q.cnt < dscp_pkg::SPI_FRAME_CNT) begin
            p_d.sh = {p_q.sh[14:0], serial_data_bidir_i};
            p_d.cnt = p_q.cnt + 5'h01;
            if (p_q.cnt == dscp_pkg::SPI_DIR_CNT) begin
                p_d.wr = serial_data_bidir_i;
            end
            if (p_q.cnt == dscp_pkg::SPI_ADDR_CNT) begin
                p_d.addr = {p_q.sh[6:0], serial_data_bidir_i};
            end
        end
    end

    always_ff @(posedge serial_clock_i or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            p_q <= '{cnt: 5'h00, sh: 16'h0000, wr: 1'b0, addr: 8'h00};
        end else begin
            p_q <= p_d;
        end
    end

    // Link domain, falling edge: read data out and write commit
    always_comb begin
        logic [7:0] rd;
        rd = dscp_rdmux(p_q.addr, s_q.page, s_q.cfg, s_q.srst, spi_rd_data_i);
        n_d = n_q;
        if (p_q.cnt != dscp_pkg::SPI_FRAME_CNT) begin
            n_d.done = 1'b0;
        end
        if (!chip_select_low_ni && p_q.wr != dscp_pkg::SPI_DIR_WR) begin
            if (p_q.cnt == dscp_pkg::SPI_RD_CNT) begin
                n_d.serial_data_return = rd[7];
                n_d.tx = {rd[6:0], 1'b0};
            end else if (p_q.cnt > dscp_pkg::SPI_RD_CNT && p_q.cnt < dscp_pkg::SPI_FRAME_CNT) begin
                n_d.serial_data_return = n_q.tx[7];
                n_d.tx = {n_q.tx[6:0], 1'b0};
            end
        end
        if (!chip_select_low_ni && p_q.wr == dscp_pkg::SPI_DIR_WR
            && p_q.cnt == dscp_pkg::SPI_FRAME_CNT && !n_q.done) begin
            n_d.done = 1'b1;
            n_d.tog = ~n_q.tog;
            n_d.waddr = p_q.addr;
            n_d.wdata = p_q.sh[7:0];
        end
    end

    always_ff @(negedge serial_clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            n_q <= '{tx: 8'h00, serial_data_return: 1'b0, done: 1'b0, tog: 1'b0, waddr: 8'h00,
                     wdata: 8'h00};
        end else begin
            n_q <= n_d;
        end
    end

    // Outputs
    assign serial_data_bidir_o = s_q.sda_o;
    assign serial_data_bidir_oe_o = s_q.sda_oe;
    assign serial_data_return_o = n_q.serial_data_return;
    assign serial_data_return_oe_o = s_q.sdo_oe;
    assign reg_wr_o = s_q.reg_wr;
    assign reg_rd_o = s_q.reg_rd;
    assign reg_page_o = s_q.page;
    assign reg_addr_o = s_q.reg_addr;
    assign reg_wdata_o = s_q.reg_wdata;
    assign spi_rd_addr_o = p_q.addr;
    assign chip_reset_o = s_q.srst[dscp_pkg::SRST_BIT];

endmodule : dscp_top

// ---- pkg/dscp_pkg.sv ----
package dscp_pkg;

    // Bus address
    localparam logic [4:0] DEF_UPPER     = 5'h1A;
    localparam int         CFG_OVR_BIT   = 7;
    localparam int         CFG_HI_BIT    = 6;
    localparam int         CFG_LO_BIT    = 2;

    // Local register offsets
    localparam logic [7:0] ADDR_CFG_OFS  = 8'h2A;
    localparam logic [7:0] SOFT_RST_OFS  = 8'hFE;
    localparam logic [7:0] PAGE_SEL_OFS  = 8'hFF;
    localparam logic [7:0] PAGE_GENERIC  = 8'h00;
    localparam int         SRST_BIT      = 0;

    // Reset values
    localparam logic [7:0] ADDR_CFG_RST  = 8'h00;
    localparam logic [7:0] SOFT_RST_RST  = 8'h00;
    localparam logic [7:0] PAGE_SEL_RST  = 8'h00;

    // Mode strap levels
    localparam logic       MODE_TWO_WIRE = 1'b1;
    localparam logic       MODE_FOUR_WIRE = 1'b0;

    // Two-wire byte handling
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [3:0] FIRST_BIT     = 4'h1;
    localparam logic [1:0] PH_SLAVE      = 2'h0;
    localparam logic [1:0] PH_REG        = 2'h1;
    localparam logic [1:0] PH_DATA       = 2'h2;

    // Four-wire frame positions, as counts of rising edges already seen
    localparam logic [4:0] SPI_DIR_CNT   = 5'h07;
    localparam logic [4:0] SPI_ADDR_CNT  = 5'h0F;
    localparam logic [4:0] SPI_RD_CNT    = 5'h10;
    localparam logic [4:0] SPI_FRAME_CNT = 5'h18;
    localparam logic       SPI_DIR_WR    = 1'b1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_TX   = 5'b01000,
        ST_RACK = 5'b10000
    } dscp_tw_st_t;

endpackage : dscp_pkg

// ---- verification/dscp_top_sva.sv ----
module dscp_chk (
    // System
    input wire logic       clk_i,
    input wire logic       resetn_i,
    // Serial link
    input wire logic       port_mode_select_i,
    input wire logic       serial_clock_i,
    input wire logic       chip_select_low_ni,
    input wire logic       serial_data_bidir_i,
    input wire logic       serial_data_bidir_o,
    input wire logic       serial_data_bidir_oe_o,
    input wire logic       serial_data_return_o,
    input wire logic       serial_data_return_oe_o,
    // Register map
    input wire logic       reg_wr_o,
    input wire logic       reg_rd_o,
    input wire logic [7:0] reg_addr_o,
    input wire logic [7:0] reg_wdata_o,
    input wire logic [7:0] spi_rd_addr_o,
    input wire logic [7:0] spi_rd_data_i,
    input wire logic       chip_reset_o
);
    logic [4:0] cnt_q;
    logic [7:0] adr_q;
    logic       dir_q;
    logic       rd_win;

    // Rising edges seen in the current frame
    always_ff @(posedge serial_clock_i or posedge chip_select_low_ni) begin
        if (chip_select_low_ni) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h1F) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Direction bit and address as shifted in
    always_ff @(posedge serial_clock_i) begin
        if (cnt_q == dscp_pkg::SPI_DIR_CNT) begin
            dir_q <= serial_data_bidir_i;
        end
        if (cnt_q > dscp_pkg::SPI_DIR_CNT && cnt_q < dscp_pkg::SPI_RD_CNT) begin
            adr_q <= {adr_q[6:0], serial_data_bidir_i};
        end
    end

    assign rd_win = !chip_select_low_ni && !dir_q;

    sequence s_four;
        (port_mode_select_i == dscp_pkg::MODE_FOUR_WIRE) [*6];
    endsequence
    sequence s_two;
        (port_mode_select_i == dscp_pkg::MODE_TWO_WIRE) [*6];
    endsequence
    property p_pulse(sig);
        @(posedge clk_i) disable iff (!resetn_i) sig |=> !sig;
    endproperty

    chk_wr_single: assert property (p_pulse(reg_wr_o)) else $error("write strobe long");
    chk_rd_single: assert property (p_pulse(reg_rd_o)) else $error("read strobe long");
    chk_open_drain: assert property (@(posedge clk_i) disable iff (!resetn_i)
        serial_data_bidir_o == 1'b0) else $error("data line driven high");
    chk_four_pins: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_four |-> serial_data_return_oe_o && !serial_data_bidir_oe_o) else $error("four-wire");
    chk_two_pins: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_two |-> !serial_data_return_oe_o) else $error("two-wire pins");
    chk_reset_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(chip_reset_o) |-> ##[0:1] (reg_addr_o == dscp_pkg::SOFT_RST_OFS
        && reg_wdata_o[dscp_pkg::SRST_BIT])) else $error("soft reset set");
    chk_reset_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(chip_reset_o) |-> ##[0:1] (reg_addr_o == dscp_pkg::SOFT_RST_OFS
        && !reg_wdata_o[dscp_pkg::SRST_BIT])) else $error("soft reset clear");
    chk_no_echo: assert property (@(negedge serial_clock_i) disable iff (!resetn_i)
        !chip_select_low_ni && cnt_q > 5'h01 && (cnt_q <= 5'h10 || dir_q)
        |-> $stable(serial_data_return_o)) else $error("serial out echoed");
    chk_read_bits: assert property (@(posedge serial_clock_i) disable iff (!resetn_i)
        rd_win && cnt_q >= dscp_pkg::SPI_RD_CNT && cnt_q < dscp_pkg::SPI_FRAME_CNT
        |-> serial_data_return_o == spi_rd_data_i[5'h17 - cnt_q]) else $error("read bit");
    chk_read_addr: assert property (@(posedge serial_clock_i) disable iff (!resetn_i)
        rd_win && cnt_q == dscp_pkg::SPI_RD_CNT |-> spi_rd_addr_o == adr_q)
        else $error("read address wrong");
endmodule : dscp_chk

bind dscp_top dscp_chk u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .port_mode_select_i(port_mode_select_i),
    .serial_clock_i(serial_clock_i), .chip_select_low_ni(chip_select_low_ni),
    .serial_data_bidir_i(serial_data_bidir_i), .serial_data_bidir_o(serial_data_bidir_o),
    .serial_data_bidir_oe_o(serial_data_bidir_oe_o),
    .serial_data_return_o(serial_data_return_o),
    .serial_data_return_oe_o(serial_data_return_oe_o), .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .spi_rd_addr_o(spi_rd_addr_o), .spi_rd_data_i(spi_rd_data_i), .chip_reset_o(chip_reset_o)
);

// ---- verification/dscp_host.sv ----
module dscp_host (
    // Serial lines to the port
    output logic      scl_o,
    output logic      csn_o,
    output logic      dat_o,
    input wire logic  sda_i,
    input wire logic  sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int q = 625;

    initial begin
        scl_o = 1'b1;
        csn_o = 1'b1;
        dat_o = 1'b1;
    end

    task automatic tw_start();
        dat_o = 1'b1;
        scl_o = 1'b1;
        #q dat_o = 1'b0;
        #q;
    endtask : tw_start

    task automatic tw_stop();
        scl_o = 1'b0;
        #q dat_o = 1'b0;
        #q scl_o = 1'b1;
        #q dat_o = 1'b1;
        #q;
    endtask : tw_stop

    // Eight bits then the acknowledge slot
    task automatic tw_xfer(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic ack);
        logic [8:0] b;
        logic [8:0] s;
        b = {tx, mack};
        for (int i = 8; i >= 0; i--) begin
            scl_o = 1'b0;
            #q dat_o = b[i];
            #q scl_o = 1'b1;
            #q s = {s[7:0], sda_i};
            #q;
        end
        rx = s[8:1];
        ack = s[0];
    endtask : tw_xfer

    task automatic spi_frame(input logic [23:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        scl_o = 1'b0;
        #3.7 csn_o = 1'b0;
        #2;
        for (int i = 0; i < n; i++) begin
            dat_o = tx[23 - i];
            #24 scl_o = 1'b1;
            rx = {rx[6:0], sdo_i};
            #24 scl_o = 1'b0;
        end
        #24 csn_o = 1'b1;
        dat_o = ~dat_o;
        #96;
    endtask : spi_frame
endmodule : dscp_host

// ---- verification/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i, resetn_i, mode, a_up, a_lo;
    logic        scl, csn, hdat, sda_oe, serial_data_return, chip_rst, wr, rd;
    logic [7:0]  addr, wdata, sra, pg;
    logic [16:0] expq[$];
    logic [16:0] exp_v;
    logic [31:0] lfsr;
    int          bad_count, comparisons, cyc;
    // Open-drain data line with pull-up
    wire         sda = hdat & ~sda_oe;

    dscp_top DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .port_mode_select_i(mode),
        .addr_select_upper_i(a_up), .addr_select_lower_i(a_lo),
        .serial_clock_i(scl), .chip_select_low_ni(csn), .serial_data_bidir_i(sda),
        .serial_data_bidir_o(), .serial_data_bidir_oe_o(sda_oe),
        .serial_data_return_o(serial_data_return), .serial_data_return_oe_o(),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_page_o(pg), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(addr ^ 8'h5A),
        .spi_rd_addr_o(sra), .spi_rd_data_i(sra ^ 8'h5A), .chip_reset_o(chip_rst)
    );

    dscp_host host (.scl_o(scl), .csn_o(csn), .dat_o(hdat), .sda_i(sda), .sdo_i(serial_data_return));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic tw(input logic [6:0] dev, input logic [7:0] ra, d, input int n,
                      input logic hit);
        logic       a;
        logic [7:0] r;
        host.tw_start();
        host.tw_xfer({dev, 1'b0}, 1'b1, r, a);
        check(17'(a), 17'(!hit));
        if (hit) begin
            host.tw_xfer(ra, 1'b1, r, a);
            check(17'(a), 17'h0);
            if (n > 1) begin
                expq.push_back({1'b1, ra, d});
                host.tw_xfer(d, 1'b1, r, a);
                check(17'(a), 17'h0);
            end
        end
        host.tw_stop();
    endtask : tw

    task automatic tw_rd(input logic [7:0] ra, input int n);
        logic       a;
        logic [7:0] r;
        tw(7'h69, ra, 8'h00, 1, 1'b1);
        host.tw_start();
        expq.push_back({1'b0, ra, 8'h00});
        host.tw_xfer(8'hD3, 1'b1, r, a);
        check(17'(a), 17'h0);
        for (int i = 0; i < n; i++) begin
            if (i < n - 1) begin
                expq.push_back({1'b0, ra + 8'(i + 1), 8'h00});
            end
            host.tw_xfer(8'hFF, i == n - 1, r, a);
            check(17'(r), 17'(ra + 8'(i)) ^ 17'h5A);
        end
        host.tw_stop();
    endtask : tw_rd

    task automatic spi(input logic [7:0] dir, ra, d, input int n);
        logic [7:0] r;
        if (dir[0] && n == 24) begin
            expq.push_back({1'b1, ra, d});
        end
        host.spi_frame({dir, ra, d}, n, r);
        if (!dir[0]) begin
            check(17'(r), 17'(ra ^ 8'h5A));
        end
    endtask : spi

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Register map activity against the noted expectations
    always @(negedge clk_i) begin
        cyc++;
        if (wr || rd) begin
            exp_v = expq.size() > 0 ? expq.pop_front() : 17'h1FFFF;
            check({wr, addr, wr ? wdata : 8'h00}, exp_v);
        end
        if (cyc == 60000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        resetn_i = 1'b0;
        mode = dscp_pkg::MODE_TWO_WIRE;
        a_up = 1'b0;
        a_lo = 1'b1;
        lfsr = 32'h7E18D809;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) resetn_i <= 1'b1;
        repeat (10) @(negedge clk_i);
        lfsr = nxt(lfsr);
        tw(7'h69, 8'h10, lfsr[7:0], 2, 1'b1);
        host.q = 100;
        tw(7'h68, 8'h10, 8'h00, 2, 1'b0);
        tw_rd(8'h20, 2);
        tw(7'h69, 8'h2A, 8'h94, 2, 1'b1);
        tw(7'h69, 8'h11, 8'h00, 2, 1'b0);
        tw(7'h15, 8'hFE, 8'h01, 2, 1'b1);
        check(17'(chip_rst), 17'h1);
        tw(7'h15, 8'h11, 8'h00, 2, 1'b0);
        tw(7'h69, 8'hFE, 8'h00, 2, 1'b1);
        check(17'(chip_rst), 17'h0);
        tw(7'h69, 8'hFF, 8'h03, 2, 1'b1);
        check(17'(pg), 17'h3);
        tw(7'h69, 8'h2A, 8'h94, 2, 1'b1);
        tw(7'h15, 8'h11, 8'h00, 2, 1'b0);
        @(negedge clk_i) {a_up, a_lo} <= 2'b10;
        tw(7'h6A, 8'h12, lfsr[15:8], 2, 1'b1);
        @(negedge clk_i) mode <= dscp_pkg::MODE_FOUR_WIRE;
        repeat (10) @(negedge clk_i);
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            spi({lfsr[7:1], 1'b1}, {2'b01, lfsr[13:8]}, lfsr[23:16], 24);
            spi({lfsr[31:25], 1'b0}, {2'b01, lfsr[21:16]}, 8'h00, 24);
        end
        spi(8'h01, 8'h44, 8'h55, 20);
        spi(8'h00, 8'h45, 8'h00, 24);
        repeat (40) @(negedge clk_i);
        check(17'(expq.size()), 17'h0);
        results();
    end
endmodule : tb
